// [logic/lsd_top.sv]
// LED sink driver: serial shift register, load latch, blanking and channel stagger
`timescale 1ns/100ps
module lsd_top (
   input wire logic I_CLOCK,
   input wire logic I_NRST,
   input wire logic I_SERIAL_CLK,
   input wire logic I_SERIAL_DATA_IN,
   input wire logic I_LOAD,
   input wire logic I_LOAD_DRIVEN,
   input wire logic I_DISABLE,
   input wire logic I_DISABLE_DRIVEN,
   output logic O_SERIAL_DATA_OUT,
   output logic [7:0] O_SINK_CHANNEL_OUTPUTS
);
   // ----------------------------------------
   // Pin pulls and synchronisers
   // ----------------------------------------
   logic load_pin;
   logic dis_pin;
   logic sclk_s;
   logic sdi_s;
   logic load_s;
   logic dis_s;

   assign load_pin = I_LOAD & I_LOAD_DRIVEN;
   assign dis_pin = I_DISABLE | ~I_DISABLE_DRIVEN;

   lsd_sync u_sclk (
      .i_clk(I_CLOCK),
      .i_nrst(I_NRST),
      .i_rst_val(1'b0),
      .i_async(I_SERIAL_CLK),
      .o_sync(sclk_s)
   );
   lsd_sync u_sdi (
      .i_clk(I_CLOCK),
      .i_nrst(I_NRST),
      .i_rst_val(1'b0),
      .i_async(I_SERIAL_DATA_IN),
      .o_sync(sdi_s)
   );
   lsd_sync u_load (
      .i_clk(I_CLOCK),
      .i_nrst(I_NRST),
      .i_rst_val(1'b0),
      .i_async(load_pin),
      .o_sync(load_s)
   );
   // Blanked during lockout, so no channel can glitch on at release
   lsd_sync u_dis (
      .i_clk(I_CLOCK),
      .i_nrst(I_NRST),
      .i_rst_val(1'b1),
      .i_async(dis_pin),
      .o_sync(dis_s)
   );

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef enum logic [1:0] {
      LSD_IDLE = 2'b00,
      LSD_STEP = 2'b01,
      LSD_WAIT = 2'b11
   } lsd_stg_e;

   typedef struct packed {
      logic sclk_d;
      logic [7:0] shift;
      logic [7:0] latch;
      logic [7:0] applied;
      logic [7:0] sink;
      logic sdo;
      lsd_stg_e stg;
      logic [2:0] ch;
      logic [3:0] cnt;
   } lsd_state_s;

   lsd_state_s st_r;
   lsd_state_s st_nxt;
   logic sclk_rise;

   assign sclk_rise = sclk_s & ~st_r.sclk_d;

   always_comb begin
      st_nxt = st_r;
      st_nxt.sclk_d = sclk_s;
      if (sclk_rise) begin
         st_nxt.shift = {st_r.shift[6:0], sdi_s};
         st_nxt.sdo = st_r.shift[7];
      end
      // Transparent while high, so the latch sees the freshly shifted value
      if (load_s) begin
         st_nxt.latch = st_nxt.shift;
      end
      // Low load leaves latch untouched, which is the hold after the fall
      // Stagger walker: channel n+1 copies latch a step after channel n
      case (st_r.stg)
         LSD_IDLE: begin
            if (st_r.applied != st_r.latch) begin
               st_nxt.applied[0] = st_r.latch[0];
               st_nxt.ch = 3'h1;
               st_nxt.cnt = 4'(lsd_pkg::STAGGER_CYC - 1);
               st_nxt.stg = (lsd_pkg::STAGGER_CYC > 1) ? LSD_WAIT : LSD_STEP;
            end
         end
         LSD_WAIT: begin
            st_nxt.cnt = st_r.cnt - 4'h1;
            if (st_r.cnt <= 4'h1) begin
               st_nxt.stg = LSD_STEP;
            end
         end
         LSD_STEP: begin
            st_nxt.applied[st_r.ch] = st_r.latch[st_r.ch];
            if (st_r.ch == lsd_pkg::CH_LAST) begin
               st_nxt.stg = LSD_IDLE;
            end else begin
               st_nxt.ch = st_r.ch + 3'h1;
               st_nxt.cnt = 4'(lsd_pkg::STAGGER_CYC - 1);
               st_nxt.stg = (lsd_pkg::STAGGER_CYC > 1) ? LSD_WAIT : LSD_STEP;
            end
         end
         default: begin
            st_nxt.stg = LSD_IDLE;
         end
      endcase
      // Blanking acts at once and does not touch the latch
      if (dis_s) begin
         st_nxt.sink = lsd_pkg::SINK_OFF;
      end else begin
         st_nxt.sink = st_nxt.applied;
      end
   end

   always_ff @(posedge I_CLOCK) begin
      if (!I_NRST) begin
         st_r.sclk_d <= 1'b0;
         st_r.shift <= lsd_pkg::SHIFT_RESET;
         st_r.latch <= lsd_pkg::LATCH_RESET;
         st_r.applied <= lsd_pkg::SINK_OFF;
         st_r.sink <= lsd_pkg::SINK_OFF;
         st_r.sdo <= 1'b0;
         st_r.stg <= LSD_IDLE;
         st_r.ch <= 3'h0;
         st_r.cnt <= 4'h0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign O_SERIAL_DATA_OUT = st_r.sdo;
   assign O_SINK_CHANNEL_OUTPUTS = st_r.sink;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   a_shift_on_edge: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
      sclk_rise |=> st_r.shift[0] == $past(sdi_s))
      else $error("shift input bit not taken");

   a_shift_advance: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
      sclk_rise |=> st_r.shift[7:1] == $past(st_r.shift[6:0]))
      else $error("shift did not advance");

   a_shift_hold: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
      !sclk_rise |=> $stable(st_r.shift))
      else $error("shift moved without clock edge");

   a_latch_follow: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
      load_s |=> st_r.latch == st_r.shift)
      else $error("latch not transparent");

   a_latch_hold: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
      !load_s |=> $stable(st_r.latch))
      else $error("latch changed while load low");

   a_blank_off: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
      dis_s |=> st_r.sink == 8'h00)
      else $error("channels on while disabled");

   a_enable_follow: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
      !dis_s |=> st_r.sink == $past(st_nxt.applied))
      else $error("channels not following latch");

   a_sdo_last: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
      sclk_rise |=> O_SERIAL_DATA_OUT == $past(st_r.shift[7]))
      else $error("serial out not last stage");

   a_sdo_stable: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
      !sclk_rise |=> $stable(O_SERIAL_DATA_OUT))
      else $error("serial out moved without edge");

   a_stagger_order: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
      (st_r.stg == LSD_IDLE && st_r.applied != st_r.latch && st_r.applied[7] != st_r.latch[7])
      |=> st_r.applied[7] == $past(st_r.applied[7]))
      else $error("last channel switched with first");

   a_stagger_done: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
      (st_r.stg == LSD_IDLE && st_r.applied != st_r.latch) |-> ##[1:40] st_r.stg == LSD_IDLE)
      else $error("stagger walk did not finish");

   // ----------------------------------------
   // Assertions: lockout, blanking, causes of change, load and walk
   // ----------------------------------------
   // No disable here: these watch the lockout itself
   a_lockout_clear: assert property (@(posedge I_CLOCK)
      !I_NRST |=> st_r.shift == 8'h00 && st_r.latch == 8'h00 && st_r.sink == 8'h00)
      else $error("lockout left state set");

   a_lockout_sdo: assert property (@(posedge I_CLOCK)
      !I_NRST |=> !O_SERIAL_DATA_OUT)
      else $error("serial out high in lockout");

   a_lockout_walk: assert property (@(posedge I_CLOCK)
      !I_NRST |=> st_r.stg == LSD_IDLE)
      else $error("stagger walk busy in lockout");

   a_blank_keeps: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
      (dis_s && !load_s) |=> $stable(st_r.latch))
      else $error("blanking disturbed latch");

   a_blank_at_once: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
      $rose(dis_s) |=> st_r.sink == 8'h00)
      else $error("blanking not immediate");

   a_unblank_follow: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
      $fell(dis_s) |=> st_r.sink == st_r.applied)
      else $error("unblank not showing latch");

   a_sink_masked: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
      !dis_s |=> (st_r.sink & ~st_r.applied) == 8'h00)
      else $error("channel on without latch bit");

   a_shift_cause: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
      $changed(st_r.shift) |-> $past(sclk_rise))
      else $error("shift changed without serial edge");

   a_sdo_cause: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
      $changed(O_SERIAL_DATA_OUT) |-> $past(sclk_rise))
      else $error("serial out changed without edge");

   a_latch_cause: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
      $changed(st_r.latch) |-> $past(load_s))
      else $error("latch changed without load");

   a_latch_rise: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
      $rose(load_s) |=> st_r.latch == st_r.shift)
      else $error("load rise did not copy shift");

   a_walk_first: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
      (st_r.stg == LSD_IDLE && st_r.applied != st_r.latch) |=> st_r.applied[0] == $past(st_r.latch[0]))
      else $error("first channel not switched first");

   a_walk_leaves: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
      (st_r.stg == LSD_IDLE && st_r.applied != st_r.latch) |=> st_r.stg != LSD_IDLE)
      else $error("stagger walk did not start");

   a_walk_start_ch: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
      (st_r.stg == LSD_IDLE && st_r.applied != st_r.latch) |=> st_r.ch == 3'h1)
      else $error("walk did not start at second channel");

   a_walk_busy_ch: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
      st_r.stg != LSD_IDLE |-> st_r.ch != 3'h0)
      else $error("walk busy on first channel");

   a_step_advance: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
      (st_r.stg == LSD_STEP && st_r.ch != lsd_pkg::CH_LAST) |=> st_r.ch == $past(st_r.ch) + 3'h1)
      else $error("walk skipped a channel");

   a_step_end: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
      (st_r.stg == LSD_STEP && st_r.ch == lsd_pkg::CH_LAST) |=> st_r.stg == LSD_IDLE)
      else $error("walk did not end at last channel");

   a_idle_quiet: assert property (@(posedge I_CLOCK) disable iff (!I_NRST)
      (st_r.stg == LSD_IDLE && st_r.applied == st_r.latch) |=> $stable(st_r.applied))
      else $error("channels moved with latch unchanged");
endmodule // lsd_top

// [logic/lsd_pkg.sv]
// Constants shared by the LED sink shift/latch control block
package lsd_pkg;
   localparam int CHANNELS = 8;
   localparam int CLK_PERIOD_NS = 40;
   localparam int STAGGER_NS = 17;
   // Least time rounds up, never below one cycle
   localparam int STAGGER_CYC_RAW = (STAGGER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STAGGER_CYC = (STAGGER_CYC_RAW < 1) ? 1 : STAGGER_CYC_RAW;
   localparam logic [7:0] SHIFT_RESET = 8'h00;
   localparam logic [7:0] LATCH_RESET = 8'h00;
   localparam logic [7:0] SINK_OFF = 8'h00;
   localparam logic [2:0] CH_LAST = 3'h7;
endpackage : lsd_pkg

// [logic/lsd_sync.sv]
// Two-flop synchroniser for one pin input
`timescale 1ns/100ps
module lsd_sync (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_rst_val,
   input wire logic i_async,
   output logic o_sync
);
   typedef struct packed {
      logic meta;
      logic sync;
   } lsd_sync_s;
   lsd_sync_s s_r;
   lsd_sync_s s_nxt;
   always_comb begin
      s_nxt.meta = i_async;
      s_nxt.sync = s_r.meta;
   end
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         s_r <= '0;
         s_r.meta <= 1'b0;
         s_r.sync <= 1'b0;
      end else begin
         s_r <= s_nxt;
      end
   end
   // Reset value mux is outside the flop: flops take constants only
   assign o_sync = i_nrst ? s_r.sync : i_rst_val;
endmodule // lsd_sync

// [testbench/lsd_host_model.sv]
// Host model driving the serial chain pins
`timescale 1ns/100ps
module lsd_host_model (
   input wire logic i_clk,
   input wire logic i_sdo,
   output logic o_sclk,
   output logic o_sdi,
   output logic o_load
);
   initial begin
      o_sclk = 1'b0;
      o_sdi = 1'b0;
      o_load = 1'b0;
   end
   // MSB first; q gets what the chain output shows after each edge
   task automatic send(input logic [7:0] b, output logic [7:0] q);
      @(negedge i_clk);
      for (int i = 7; i >= 0; i--) begin
         o_sdi = b[i];
         repeat (4) @(negedge i_clk);
         o_sclk = 1'b1;
         repeat (4) @(negedge i_clk);
         o_sclk = 1'b0;
         q[i] = i_sdo;
      end
      repeat (4) @(negedge i_clk);
      // Past hold time the line no longer shows the last bit
      o_sdi = ~o_sdi;
   endtask
endmodule // lsd_host_model

// [testbench/test_lsd_top.sv]
// Self-checking bench for the LED sink shift/latch block
`timescale 1ns/100ps
module test_lsd_top;
   logic clk, nrst, sclk, sdi, load, load_drv, dis, dis_drv, sdo;
   logic [7:0] sink, q;
   int fail_count = 0;
   int n_tests = 0;
   lsd_top i_dut (.I_CLOCK(clk), .I_NRST(nrst), .I_SERIAL_CLK(sclk), .I_SERIAL_DATA_IN(sdi),
      .I_LOAD(load), .I_LOAD_DRIVEN(load_drv), .I_DISABLE(dis), .I_DISABLE_DRIVEN(dis_drv),
      .O_SERIAL_DATA_OUT(sdo), .O_SINK_CHANNEL_OUTPUTS(sink));
   lsd_host_model i_host (.i_clk(clk), .i_sdo(sdo), .o_sclk(sclk), .o_sdi(sdi), .o_load(load));
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic settle;
      repeat (20) @(negedge clk);
   endtask
   // ---
   // Scenarios
   // ---
   task automatic t_load;
      check("rst", sink, 8'h00);
      i_host.send(8'hA5, q);
      check("sdo0", q, 8'h00);
      i_host.o_load = 1'b1;
      settle();
      i_host.o_load = 1'b0;
      settle();
      check("sink", sink, 8'hA5);
   endtask
   task automatic t_follow;
      i_host.send(8'h3C, q);
      check("chain", q, 8'hA5);
      check("hold", sink, 8'hA5);
      i_host.o_load = 1'b1;
      settle();
      check("copy", sink, 8'h3C);
      i_host.send(8'hC3, q);
      settle();
      check("track", sink, 8'hC3);
      i_host.o_load = 1'b0;
      i_host.send(8'h00, q);
      check("frozen", sink, 8'hC3);
      check("order", q, 8'hC3);
   endtask
   task automatic t_blank;
      dis = 1'b1;
      settle();
      check("blank", sink, 8'h00);
      dis = 1'b0;
      settle();
      check("unblank", sink, 8'hC3);
      dis_drv = 1'b0;
      settle();
      check("pullup", sink, 8'h00);
      dis_drv = 1'b1;
      load_drv = 1'b0;
      i_host.o_load = 1'b1;
      settle();
      check("pulldn", sink, 8'hC3);
      i_host.o_load = 1'b0;
      load_drv = 1'b1;
   endtask
   task automatic t_stagger;
      int n;
      i_host.send(8'h3C, q);
      i_host.o_load = 1'b1;
      for (n = 0; n < 50 && sink[0] !== 1'b0; n++) @(negedge clk);
      for (n = 0; n < 50 && sink[7] !== 1'b0; n++) @(negedge clk);
      i_host.o_load = 1'b0;
      check("stagger", n[7:0], 8'(7 * lsd_pkg::STAGGER_CYC));
   endtask
   task automatic t_reset;
      nrst = 1'b0;
      repeat (4) @(negedge clk);
      check("clr", sink, 8'h00);
      nrst = 1'b1;
      repeat (4) @(negedge clk);
      i_host.send(8'h00, q);
      check("clrsh", q, 8'h00);
   endtask
   initial begin
      nrst = 1'b0;
      dis = 1'b0;
      dis_drv = 1'b1;
      load_drv = 1'b1;
      repeat (8) @(negedge clk);
      nrst = 1'b1;
      repeat (4) @(negedge clk);
      t_load();
      t_follow();
      t_blank();
      t_stagger();
      t_reset();
      give_verdict();
   end
   initial begin
      #200000;
      fail_count++;
      give_verdict();
   end
endmodule // test_lsd_top
